// ---- hdl/dmd_pkg.sv ----
/*
 * Constants, field layout and mode types of the demodulator configuration block.
 * Assumes a single 100 MHz clock; nothing else is needed from its surroundings.
 */
package dmd_pkg;
	// ------------------------------------------------------------------
	// Register subaddresses and reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] SUB_DEMOD_CFG = 8'h09;
	localparam logic [7:0] SUB_DEEMPH    = 8'h0A;
	localparam logic [7:0] RST_DEMOD_CFG = 8'h00;
	localparam logic [7:0] RST_DEEMPH    = 8'h00;
	localparam logic [7:0] RD_UNMAPPED   = 8'h00;
	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int ID_TIME_HI   = 7;
	localparam int ID_TIME_LO   = 6;
	localparam int ID_REGION    = 5;
	localparam int FBW_HI       = 4;
	localparam int CH2_MODE_HI  = 3;
	localparam int CH2_MODE_LO  = 2;
	localparam int FBW_LO       = 1;
	localparam int CH1_AM       = 0;
	localparam int C1_NIB_LO    = 0;
	localparam int C2_NIB_LO    = 4;
	localparam int NIB_ADAPT    = 3;
	// ------------------------------------------------------------------
	// Timing: integrator tick
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS       = 10000;
	localparam int TICK_DIV      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ------------------------------------------------------------------
	// Mode types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {ID_SLOW = 2'b00, ID_MEDIUM = 2'b01, ID_FAST = 2'b10, ID_OFF = 2'b11} dmd_id_time_type;
	typedef enum logic [1:0] {CH2_FM = 2'b00, CH2_AM = 2'b01, CH2_NICAM = 2'b10, CH2_SPARE = 2'b11} dmd_ch2_mode_type;
	typedef enum logic [1:0] {BW_NARROW = 2'b00, BW_MEDIUM = 2'b01, BW_WIDE = 2'b10, BW_XWIDE = 2'b11} dmd_bw_type;
	typedef enum logic [2:0] {DE_50US = 3'b000, DE_60US = 3'b001, DE_75US = 3'b010, DE_J17 = 3'b011,
		DE_OFF = 3'b100} dmd_deemph_type;
endpackage

// ---- hdl/dmd_cfg_if.sv ----
/*
 * Carrier between the register bank and its identification timer and de-emphasis decoder.
 * Assumes all parties run on the same clock.
 */
`timescale 1ns/100ps
interface dmd_cfg_if;
	logic [1:0] ident_time;
	logic       tick;
	logic       ident_valid;
	logic       ident_period;
	logic [3:0] c1_nib;
	logic [3:0] c2_nib;
	logic [2:0] c1_char;
	logic [2:0] c2_char;
	logic       c1_adapt;
	logic       c2_adapt;
	modport ctrl   (output ident_time, tick, c1_nib, c2_nib,
	                input  ident_valid, ident_period, c1_char, c2_char, c1_adapt, c2_adapt);
	modport ident  (input ident_time, tick, output ident_valid, ident_period);
	modport deemph (input c1_nib, c2_nib, output c1_char, c2_char, c1_adapt, c2_adapt);
endinterface

// ---- hdl/dmd_ident_timer.sv ----
/*
 * FM identification integrator timer: counts integrator periods and flags a valid result.
 * Assumes tick is a one-cycle enable from the bank's divider.
 */
`timescale 1ns/100ps
module dmd_ident_timer #(
	parameter int SLOW_TICKS = 64,
	parameter int MED_TICKS  = 32,
	parameter int FAST_TICKS = 16
) (
	// Clock and reset
	input  wire logic    clk_i,
	input  wire logic    rst_b_i,
	// Configuration and status
	dmd_cfg_if.ident     cfg
);
	initial if (FAST_TICKS < 2 || MED_TICKS < FAST_TICKS || SLOW_TICKS < MED_TICKS || SLOW_TICKS > 65535)
		$error("dmd_ident_timer: bad integrator lengths");

	logic [15:0] len;
	logic [15:0] cnt_reg;
	logic [1:0]  periods_reg;
	logic [1:0]  time_last_reg;
	logic        restart;

	always_comb begin
		unique case (dmd_pkg::dmd_id_time_type'(cfg.ident_time))
			dmd_pkg::ID_SLOW:   len = 16'(SLOW_TICKS);
			dmd_pkg::ID_MEDIUM: len = 16'(MED_TICKS);
			dmd_pkg::ID_FAST:   len = 16'(FAST_TICKS);
			dmd_pkg::ID_OFF:    len = 16'(FAST_TICKS);
		endcase
	end

	// Off, or any change of speed, drops the integrator back to a clean state
	assign restart = (cfg.ident_time == dmd_pkg::ID_OFF) || (cfg.ident_time != time_last_reg);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg       <= 16'h0000;
			periods_reg   <= 2'h0;
			time_last_reg <= 2'h3;
			cfg.ident_period <= 1'b0;
		end else begin
			time_last_reg    <= cfg.ident_time;
			cfg.ident_period <= 1'b0;
			if (restart) begin
				cnt_reg     <= 16'h0000;
				periods_reg <= 2'h0;
			end else if (cfg.tick) begin
				if (cnt_reg == len - 16'h0001) begin
					cnt_reg          <= 16'h0000;
					cfg.ident_period <= 1'b1;
					if (periods_reg != 2'h2)
						periods_reg <= periods_reg + 2'h1;
				end else begin
					cnt_reg <= cnt_reg + 16'h0001;
				end
			end
		end
	end

	assign cfg.ident_valid = (periods_reg == 2'h2);

	property p_ident_off_clears;
		@(posedge clk_i) disable iff (!rst_b_i)
		(cfg.ident_time == dmd_pkg::ID_OFF) |=> !cfg.ident_valid;
	endproperty
	a_ident_off_clears: assert property (p_ident_off_clears) else $error("ident valid while off");
	property p_valid_after_two;
		@(posedge clk_i) disable iff (!rst_b_i)
		$rose(cfg.ident_valid) |-> cfg.ident_period && $past(periods_reg) == 2'h1;
	endproperty
	a_valid_after_two: assert property (p_valid_after_two) else $error("ident valid not at second period");
endmodule // dmd_ident_timer

// ---- hdl/dmd_deemph_decode.sv ----
/*
 * Decodes both de-emphasis nibbles into characteristic and adaptive enable.
 * Purely combinational; the bank registers the results.
 */
`timescale 1ns/100ps
module dmd_deemph_decode (
	// Nibbles in, decoded settings out
	dmd_cfg_if.deemph    cfg
);
	// Spare codes fall back to no de-emphasis rather than a guessed curve
	function automatic logic [2:0] decode_char(input logic [2:0] code);
		unique case (code)
			3'h0:    decode_char = dmd_pkg::DE_50US;
			3'h1:    decode_char = dmd_pkg::DE_60US;
			3'h2:    decode_char = dmd_pkg::DE_75US;
			3'h3:    decode_char = dmd_pkg::DE_J17;
			default: decode_char = dmd_pkg::DE_OFF;
		endcase
	endfunction

	assign cfg.c1_char  = decode_char(cfg.c1_nib[2:0]);
	assign cfg.c2_char  = decode_char(cfg.c2_nib[2:0]);
	assign cfg.c1_adapt = cfg.c1_nib[dmd_pkg::NIB_ADAPT];
	assign cfg.c2_adapt = cfg.c2_nib[dmd_pkg::NIB_ADAPT];
endmodule // dmd_deemph_decode

// ---- hdl/dmd_config_regs.sv ----
/*
 * Demodulator configuration and FM de-emphasis register bank with decoded steering outputs.
 * Assumes the serial control bus slave hands over one subaddressed byte per write strobe.
 */
// Summary of operation
// - Both registers clear to all zeros at power-on reset.
// - Subaddress 9 holds ident time 7:6, region 5, bandwidth bits 4 and 1, channel 2 mode 3:2, channel 1 mode 0.
// - Ident time 00 slow, 01 medium, 10 fast, 11 turns identification off and holds it in reset.
// - A valid identification result is flagged within two integrator periods of starting.
// - Turning identification off returns its hardware to a defined state.
// - Region bit one selects Korean pilot frequencies, zero the European ones.
// - Channel 2 runs FM for 00, AM for 01, NICAM for 10, with wider decimation in NICAM.
// - Channel 1 mode bit one selects AM, zero selects FM.
// - Bandwidth bits give 00 narrow/narrow, 01 extra wide/narrow, 10 medium/medium, 11 wide/wide.
// - In extra wide only channel 1 may demodulate FM while NICAM stays usable on channel 2.
// - Subaddress 10 steers carrier 1 from bits 3:0 and carrier 2 from bits 7:4, adaptive bit over a code.
// - A set adaptive bit enables adaptive de-emphasis on its carrier.
// - De-emphasis codes decode 000 50 us, 001 60 us, 010 75 us, 011 J17, 100 off.
`timescale 1ns/100ps
module dmd_config_regs #(
	parameter int SLOW_TICKS = 64,
	parameter int MED_TICKS  = 32,
	parameter int FAST_TICKS = 16
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Register access from the control bus slave
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_sub_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        easy_standard_programming_i,
	// Identification control
	output logic      [1:0]  ident_speed_o,
	output logic             ident_off_o,
	output logic             ident_korea_o,
	output logic             ident_valid_o,
	output logic             ident_period_o,
	// Channel modes and filters
	output logic             chan1_am_o,
	output logic      [1:0]  chan2_mode_o,
	output logic             chan2_fm_en_o,
	output logic             chan2_nicam_o,
	output logic             chan2_decim_wide_o,
	output logic      [1:0]  chan1_bw_o,
	output logic      [1:0]  chan2_bw_o,
	// De-emphasis
	output logic      [2:0]  carrier1_deemph_o,
	output logic      [2:0]  carrier2_deemph_o,
	output logic             carrier1_adaptive_o,
	output logic             carrier2_adaptive_o
);
	initial if (dmd_pkg::TICK_DIV < 2 || dmd_pkg::TICK_DIV > 65535)
		$error("dmd_config_regs: tick divider out of range");

	// ------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------
	logic [7:0]  demod_config_reg;
	logic [7:0]  fm_deemphasis_select_reg;
	logic [15:0] div_reg;
	logic        wr_ok;
	logic        any_wr_reg;

	dmd_cfg_if cfg ();

	// Writes during easy standard programming are dropped so the preset stays intact
	assign wr_ok = reg_wr_i && !easy_standard_programming_i;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			demod_config_reg         <= dmd_pkg::RST_DEMOD_CFG;
			fm_deemphasis_select_reg <= dmd_pkg::RST_DEEMPH;
		end else if (wr_ok) begin
			if (reg_sub_i == dmd_pkg::SUB_DEMOD_CFG)
				demod_config_reg <= reg_wdata_i;
			if (reg_sub_i == dmd_pkg::SUB_DEEMPH)
				fm_deemphasis_select_reg <= reg_wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			reg_rdata_o <= dmd_pkg::RD_UNMAPPED;
		else if (reg_rd_i) begin
			if (reg_sub_i == dmd_pkg::SUB_DEMOD_CFG)
				reg_rdata_o <= demod_config_reg;
			else if (reg_sub_i == dmd_pkg::SUB_DEEMPH)
				reg_rdata_o <= fm_deemphasis_select_reg;
			else
				reg_rdata_o <= dmd_pkg::RD_UNMAPPED;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			any_wr_reg <= 1'b0;
		else if (wr_ok)
			any_wr_reg <= 1'b1;
	end

	// ------------------------------------------------------------------
	// Integrator tick divider
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			div_reg <= 16'h0000;
		else if (div_reg == 16'(dmd_pkg::TICK_DIV - 1))
			div_reg <= 16'h0000;
		else
			div_reg <= div_reg + 16'h0001;
	end

	assign cfg.tick       = (div_reg == 16'(dmd_pkg::TICK_DIV - 1));
	assign cfg.ident_time = demod_config_reg[dmd_pkg::ID_TIME_HI:dmd_pkg::ID_TIME_LO];
	assign cfg.c1_nib     = fm_deemphasis_select_reg[dmd_pkg::C1_NIB_LO +: 4];
	assign cfg.c2_nib     = fm_deemphasis_select_reg[dmd_pkg::C2_NIB_LO +: 4];

	dmd_ident_timer #(
		.SLOW_TICKS (SLOW_TICKS),
		.MED_TICKS  (MED_TICKS),
		.FAST_TICKS (FAST_TICKS)
	) u_ident (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.cfg     (cfg)
	);

	dmd_deemph_decode u_deemph (
		.cfg (cfg)
	);

	// ------------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------------
	logic [1:0] bw_code;
	logic [1:0] ch2_code;
	logic [1:0] bw1_next;
	logic [1:0] bw2_next;
	logic [1:0] ch2_next;

	assign bw_code  = {demod_config_reg[dmd_pkg::FBW_HI], demod_config_reg[dmd_pkg::FBW_LO]};
	assign ch2_code = demod_config_reg[dmd_pkg::CH2_MODE_HI:dmd_pkg::CH2_MODE_LO];

	always_comb begin
		unique case (bw_code)
			2'b00: begin
				bw1_next = dmd_pkg::BW_NARROW;
				bw2_next = dmd_pkg::BW_NARROW;
			end
			2'b01: begin
				bw1_next = dmd_pkg::BW_XWIDE;
				bw2_next = dmd_pkg::BW_NARROW;
			end
			2'b10: begin
				bw1_next = dmd_pkg::BW_MEDIUM;
				bw2_next = dmd_pkg::BW_MEDIUM;
			end
			2'b11: begin
				bw1_next = dmd_pkg::BW_WIDE;
				bw2_next = dmd_pkg::BW_WIDE;
			end
		endcase
	end

	// Spare channel 2 code runs as FM; the stored byte keeps the written value
	assign ch2_next = (ch2_code == dmd_pkg::CH2_SPARE) ? dmd_pkg::CH2_FM : ch2_code;

	// ------------------------------------------------------------------
	// Registered steering outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ident_speed_o      <= dmd_pkg::ID_SLOW;
			ident_off_o        <= 1'b0;
			ident_korea_o      <= 1'b0;
			chan1_am_o         <= 1'b0;
			chan2_mode_o       <= dmd_pkg::CH2_FM;
			chan2_fm_en_o      <= 1'b1;
			chan2_nicam_o      <= 1'b0;
			chan2_decim_wide_o <= 1'b0;
			chan1_bw_o         <= dmd_pkg::BW_NARROW;
			chan2_bw_o         <= dmd_pkg::BW_NARROW;
		end else begin
			ident_speed_o      <= cfg.ident_time;
			ident_off_o        <= (cfg.ident_time == dmd_pkg::ID_OFF);
			ident_korea_o      <= demod_config_reg[dmd_pkg::ID_REGION];
			chan1_am_o         <= demod_config_reg[dmd_pkg::CH1_AM];
			chan2_mode_o       <= ch2_next;
			chan2_fm_en_o      <= (ch2_next == dmd_pkg::CH2_FM) && (bw1_next != dmd_pkg::BW_XWIDE);
			chan2_nicam_o      <= (ch2_next == dmd_pkg::CH2_NICAM);
			chan2_decim_wide_o <= (ch2_next == dmd_pkg::CH2_NICAM);
			chan1_bw_o         <= bw1_next;
			chan2_bw_o         <= bw2_next;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ident_valid_o       <= 1'b0;
			ident_period_o      <= 1'b0;
			carrier1_deemph_o   <= dmd_pkg::DE_50US;
			carrier2_deemph_o   <= dmd_pkg::DE_50US;
			carrier1_adaptive_o <= 1'b0;
			carrier2_adaptive_o <= 1'b0;
		end else begin
			ident_valid_o       <= cfg.ident_valid;
			ident_period_o      <= cfg.ident_period;
			carrier1_deemph_o   <= cfg.c1_char;
			carrier2_deemph_o   <= cfg.c2_char;
			carrier1_adaptive_o <= cfg.c1_adapt;
			carrier2_adaptive_o <= cfg.c2_adapt;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	property p_reset_zero;
		@(posedge clk_i) disable iff (!rst_b_i)
		!any_wr_reg |-> demod_config_reg == 8'h00 && fm_deemphasis_select_reg == 8'h00;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("registers not zero before first write");

	property p_cfg_write;
		@(posedge clk_i) disable iff (!rst_b_i)
		(wr_ok && reg_sub_i == 8'h09) |=> demod_config_reg == $past(reg_wdata_i) ##1 chan1_am_o == $past(reg_wdata_i[0], 2);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config write not stored or steered");

	property p_ident_off;
		@(posedge clk_i) disable iff (!rst_b_i)
		(demod_config_reg[7:6] == 2'b11) |=> ident_off_o ##1 !ident_valid_o;
	endproperty
	a_ident_off: assert property (p_ident_off) else $error("ident off not decoded");

	property p_region;
		@(posedge clk_i) disable iff (!rst_b_i)
		1'b1 |=> ident_korea_o == $past(demod_config_reg[5]);
	endproperty
	a_region: assert property (p_region) else $error("region bit not followed");

	property p_nicam_wide;
		@(posedge clk_i) disable iff (!rst_b_i)
		(demod_config_reg[3:2] == 2'b10) |=> chan2_decim_wide_o && chan2_nicam_o && !chan2_fm_en_o;
	endproperty
	a_nicam_wide: assert property (p_nicam_wide) else $error("NICAM decimation not wide");

	property p_bw_map;
		@(posedge clk_i) disable iff (!rst_b_i)
		({demod_config_reg[4], demod_config_reg[1]} == 2'b01) |=> chan1_bw_o == 2'b11 && chan2_bw_o == 2'b00;
	endproperty
	a_bw_map: assert property (p_bw_map) else $error("extra wide bandwidth mismatch");

	property p_xwide_no_fm2;
		@(posedge clk_i) disable iff (!rst_b_i)
		(chan1_bw_o == 2'b11) |-> !chan2_fm_en_o;
	endproperty
	a_xwide_no_fm2: assert property (p_xwide_no_fm2) else $error("channel 2 FM in extra wide");

	property p_deemph_write;
		@(posedge clk_i) disable iff (!rst_b_i)
		(wr_ok && reg_sub_i == 8'h0A) |=> fm_deemphasis_select_reg == $past(reg_wdata_i)
			##1 carrier2_adaptive_o == $past(reg_wdata_i[7], 2) && carrier1_adaptive_o == $past(reg_wdata_i[3], 2);
	endproperty
	a_deemph_write: assert property (p_deemph_write) else $error("de-emphasis write not applied");

	property p_deemph_75;
		@(posedge clk_i) disable iff (!rst_b_i)
		(fm_deemphasis_select_reg[2:0] == 3'b010) |=> carrier1_deemph_o == 3'b010;
	endproperty
	a_deemph_75: assert property (p_deemph_75) else $error("75 us code not decoded");

	property p_spare_off;
		@(posedge clk_i) disable iff (!rst_b_i)
		(fm_deemphasis_select_reg[6:4] > 3'b100) |=> carrier2_deemph_o == 3'b100;
	endproperty
	a_spare_off: assert property (p_spare_off) else $error("spare code not defaulted");

	c_nicam: cover property (@(posedge clk_i) disable iff (!rst_b_i) chan2_nicam_o && chan1_bw_o == 2'b11);
	c_ident_valid: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(ident_valid_o));
	c_adaptive: cover property (@(posedge clk_i) disable iff (!rst_b_i) carrier1_adaptive_o && carrier2_adaptive_o);
	c_easy_prog_drop: cover property (@(posedge clk_i) disable iff (!rst_b_i) reg_wr_i && easy_standard_programming_i);
endmodule // dmd_config_regs

// ---- verif/dmd_host_model.sv ----
/*
 * Host controller model that drives the register bank over its byte-wide subaddressed port.
 * Assumes the device takes a request at a rising clock edge and answers reads one cycle later.
 */
`timescale 1ns/100ps
module dmd_host_model (
	// Clock
	input  wire logic       clk_i,
	// Register port towards the device
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [7:0] reg_sub_o,
	output logic      [7:0] reg_wdata_o,
	output logic            easy_standard_programming_o,
	input  wire logic [7:0] reg_rdata_i
);
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_sub_o = 8'h00;
		reg_wdata_o = 8'h00;
		easy_standard_programming_o = 1'b0;
	end
	// ------------------------------------------------------------------
	// One request, held across the taking edge
	// ------------------------------------------------------------------
	task automatic xfer(input logic wr, input logic rd, input logic [7:0] sub, input logic [7:0] data,
		output logic [7:0] rdata);
		@(posedge clk_i);
		#1;
		reg_wr_o = wr;
		reg_rd_o = rd;
		reg_sub_o = sub;
		reg_wdata_o = data;
		@(posedge clk_i);
		#1;
		rdata = reg_rdata_i;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		// Idle lines carry garbage so stale values are never mistaken for a request
		reg_sub_o = ~sub;
		reg_wdata_o = ~data;
	endtask
	task automatic set_easy_prog(input logic on);
		@(posedge clk_i);
		#1;
		easy_standard_programming_o = on;
	endtask
	// Both carriers alike, fixed code forced to 75 us when adaptive is on
	task automatic set_deemph(input logic adapt, input logic [2:0] code);
		logic [7:0] unused;
		logic [2:0] c;
		c = adapt ? 3'b010 : code;
		xfer(1'b1, 1'b0, 8'h0A, {adapt, c, adapt, c}, unused);
	endtask
endmodule // dmd_host_model

// ---- verif/dmd_config_regs_bench.sv ----
/*
 * Self-checking bench of the configuration register bank, driven through the host model.
 * Assumes a 100 MHz clock and shortened integrator periods of 4, 3 and 2 ticks.
 */
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module dmd_config_regs_bench;
	logic        clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        reg_wr, reg_rd, easy_prog;
	logic [7:0]  reg_sub, reg_wdata, reg_rdata_o;
	logic [1:0]  ident_speed_o, chan2_mode_o, chan1_bw_o, chan2_bw_o;
	logic        ident_off_o, ident_korea_o, ident_valid_o, ident_period_o, chan1_am_o;
	logic        chan2_fm_en_o, chan2_nicam_o, chan2_decim_wide_o, carrier1_adaptive_o, carrier2_adaptive_o;
	logic [2:0]  carrier1_deemph_o, carrier2_deemph_o;
	logic [7:0]  d, r;
	int          n_fail = 0;
	int          n_compared = 0;
	int          cnt, np;
	always #5 clk_i = ~clk_i;
	dmd_config_regs #(.SLOW_TICKS(4), .MED_TICKS(3), .FAST_TICKS(2)) dmd_config_regs_inst (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_sub_i(reg_sub),
		.reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata_o), .easy_standard_programming_i(easy_prog),
		.ident_speed_o(ident_speed_o), .ident_off_o(ident_off_o), .ident_korea_o(ident_korea_o),
		.ident_valid_o(ident_valid_o), .ident_period_o(ident_period_o), .chan1_am_o(chan1_am_o),
		.chan2_mode_o(chan2_mode_o), .chan2_fm_en_o(chan2_fm_en_o), .chan2_nicam_o(chan2_nicam_o),
		.chan2_decim_wide_o(chan2_decim_wide_o), .chan1_bw_o(chan1_bw_o), .chan2_bw_o(chan2_bw_o),
		.carrier1_deemph_o(carrier1_deemph_o), .carrier2_deemph_o(carrier2_deemph_o),
		.carrier1_adaptive_o(carrier1_adaptive_o), .carrier2_adaptive_o(carrier2_adaptive_o));
	dmd_host_model dmd_host_model_inst (
		.clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_sub_o(reg_sub),
		.reg_wdata_o(reg_wdata), .easy_standard_programming_o(easy_prog), .reg_rdata_i(reg_rdata_o));
	// ------------------------------------------------------------------
	// Expected decode
	// ------------------------------------------------------------------
	function automatic logic [13:0] exp_cfg(input logic [7:0] v);
		logic [1:0] m;
		logic [3:0] bw;
		m = (v[3:2] == 2'b11) ? 2'b00 : v[3:2];
		case ({v[4], v[1]})
			2'b00: bw = 4'h0;
			2'b01: bw = 4'hC;
			2'b10: bw = 4'h5;
			default: bw = 4'hA;
		endcase
		return {v[7:6], v[7:6] == 2'b11, v[5], v[0], m, m == 2'b00 && bw != 4'hC, m == 2'b10, m == 2'b10, bw};
	endfunction
	function automatic logic [3:0] exp_de(input logic [3:0] n);
		return {n[3], (n[2:0] > 3'b100) ? 3'b100 : n[2:0]};
	endfunction
	function automatic logic [13:0] got_cfg();
		return {ident_speed_o, ident_off_o, ident_korea_o, chan1_am_o, chan2_mode_o, chan2_fm_en_o,
			chan2_nicam_o, chan2_decim_wide_o, chan1_bw_o, chan2_bw_o};
	endfunction
	function automatic logic [7:0] got_de();
		return {carrier2_adaptive_o, carrier2_deemph_o, carrier1_adaptive_o, carrier1_deemph_o};
	endfunction
	// ------------------------------------------------------------------
	// Bus helpers
	// ------------------------------------------------------------------
	task automatic wr(input logic [7:0] sub, input logic [7:0] v);
		dmd_host_model_inst.xfer(1'b1, 1'b0, sub, v, r);
		@(posedge clk_i);
		#1;
	endtask
	task automatic rd(input logic [7:0] sub);
		dmd_host_model_inst.xfer(1'b0, 1'b1, sub, 8'h00, r);
	endtask
	task automatic report_and_stop();
		$display("compared=%0d failed=%0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#500000;
		n_fail++;
		report_and_stop();
	end
	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(13548));
		repeat (2) @(posedge clk_i);
		#1;
		rst_b_i = 1'b1;
		`CHK({got_cfg(), got_de(), ident_valid_o}, {exp_cfg(8'h00), 8'h00, 1'b0})
		rd(8'h09);
		`CHK(r, 8'h00)
		rd(8'h0A);
		`CHK(r, 8'h00)
		// Corners first, then random bytes
		for (int i = 0; i < 40; i++) begin
			case (i)
				0: d = 8'hFF;
				1: d = 8'h0C;
				2: d = 8'h2A;
				3: d = 8'h12;
				4: d = 8'h09;
				default: d = 8'($urandom);
			endcase
			wr(8'h09, d);
			`CHK(got_cfg(), exp_cfg(d))
			rd(8'h09);
			`CHK(r, d)
		end
		for (int i = 0; i < 16; i++) begin
			d = {i[3:0], ~i[3:0]};
			wr(8'h0A, d);
			`CHK(got_de(), {exp_de(d[7:4]), exp_de(d[3:0])})
			rd(8'h0A);
			`CHK(r, d)
		end
		dmd_host_model_inst.set_deemph(1'b1, 3'b000);
		@(posedge clk_i);
		#1;
		`CHK(got_de(), 8'hAA)
		// Refused writes and the unmapped subaddress
		wr(8'h09, 8'hA5);
		dmd_host_model_inst.set_easy_prog(1'b1);
		wr(8'h09, 8'h5A);
		dmd_host_model_inst.set_easy_prog(1'b0);
		wr(8'h0B, 8'hFF);
		rd(8'h0B);
		`CHK(r, 8'h00)
		dmd_host_model_inst.xfer(1'b1, 1'b1, 8'h09, 8'h3C, r);
		`CHK(r, 8'hA5)
		rd(8'h09);
		`CHK(r, 8'h3C)
		// Integrator timing for fast, medium and slow
		for (int k = 0; k < 3; k++) begin
			wr(8'h09, 8'hC0);
			@(posedge clk_i);
			#1;
			`CHK({ident_off_o, ident_valid_o}, 2'b10)
			dmd_host_model_inst.xfer(1'b1, 1'b0, 8'h09, {2'(2 - k), 6'h00}, r);
			cnt = 0;
			np = 0;
			while (ident_valid_o !== 1'b1 && cnt < 20000) begin
				@(posedge clk_i);
				#1;
				cnt++;
				np += int'(ident_period_o);
			end
			`CHK(cnt >= (2 * (2 + k) - 1) * 1000 - 2 && cnt <= 2 * (2 + k) * 1000 + 4, 1'b1)
			`CHK(np, 2)
			`CHK(ident_speed_o, 2'(2 - k))
		end
		wr(8'h09, 8'hE0);
		@(posedge clk_i);
		#1;
		`CHK({ident_valid_o, ident_off_o, ident_korea_o}, 3'b011)
		report_and_stop();
	end
endmodule // dmd_config_regs_bench
